/* verilog/adc_ctrl_pkg.sv */
// Package with register map, field layout and encodings of the converter control block
package adc_ctrl_pkg;

    localparam int DATA_W = 14;

    // Register select codes on the two address inputs
    localparam logic [1:0] SEL_RESULT  = 2'h0;
    localparam logic [1:0] SEL_GAIN    = 2'h1;
    localparam logic [1:0] SEL_OFFSET  = 2'h2;
    localparam logic [1:0] SEL_CONTROL = 2'h3;

    // Control register field positions
    localparam int CTL_PWD_BIT = 13;
    localparam int CTL_REF_BIT = 12;
    localparam int CTL_FMT_BIT = 11;
    localparam int CTL_TM_LSB  = 8;
    localparam int CTL_OFF_BIT = 7;

    // Gain field and offset field widths
    localparam int GAIN_W   = 3;
    localparam int OFFSET_W = 8;

    // Reset values of the writable registers
    localparam logic [13:0] GAIN_RST    = 14'h0000;
    localparam logic [13:0] OFFSET_RST  = 14'h0000;
    localparam logic [13:0] CONTROL_RST = 14'h0000;

    // Stages between sample capture and the data bus
    localparam int PIPE_DEPTH = 3;

    // Test input selections
    typedef enum logic [2:0] {
        TM_NORMAL0  = 3'h0,
        TM_BOTH_LO  = 3'h1,
        TM_MID_LO   = 3'h2,
        TM_HI_LO    = 3'h3,
        TM_NORMAL1  = 3'h4,
        TM_BOTH_HI  = 3'h5,
        TM_LO_MID   = 3'h6,
        TM_LO_HI    = 3'h7
    } selftest_input_select_e;

    // Analog input source levels
    typedef enum logic [1:0] {
        SRC_SIGNAL = 2'h0,
        SRC_REF_LO = 2'h1,
        SRC_REF_MID = 2'h2,
        SRC_REF_HI = 2'h3
    } input_source_e;

    // Routing of the two converter inputs
    typedef struct packed {
        input_source_e pos;
        input_source_e neg;
    } input_route_s;

    // One sample travelling through the output pipeline
    typedef struct packed {
        logic [13:0] code;
        logic        out_of_range;
    } sample_s;

endpackage : adc_ctrl_pkg

/* verilog/adc_host_config_and_correction.sv */
// Host-port registers, offset correction and output pipeline of the converter
`timescale 1ns/1ps

module adc_host_config_and_correction #(
    parameter int PIPE_DEPTH = adc_ctrl_pkg::PIPE_DEPTH
) (
    input  wire logic                 sys_clk,                  // 40 MHz clock
    input  wire logic                 nrst,                     // Async reset, active low
    input  wire logic                 chip_select_n,            // Chip select, active low
    input  wire logic                 write_n,                  // Write strobe, active low
    input  wire logic                 output_enable_n,          // Bus output enable, active low
    input  wire logic                 register_select_high,     // Register select bit 1
    input  wire logic                 register_select_low,      // Register select bit 0
    input  wire logic [13:0]          data_in,                  // Bus data from host
    output logic      [13:0]          data_out,                 // Bus data to host
    output logic      [13:0]          data_oe,                  // Bus drive enables
    input  wire logic                 sample_valid,             // Core produced a sample
    input  wire logic [13:0]          sample_code,              // Raw code, straight binary
    input  wire logic                 sample_over,              // Core saw input beyond range
    output logic                      out_of_range_flag,        // Flag aligned with data
    output logic      [2:0]           gain_step_code,           // Gain in dB
    output logic                      bandgap_voltage_node_ext, // High: internal bandgap off
    output logic                      power_down,               // Core power down
    output adc_ctrl_pkg::input_route_s input_route              // Converter input routing
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic       rst_meta_r;
    logic       rst_n_r;

    // Two stages so the release never meets a clock edge mid-setup
    // Only rst_n_r leaves this block; the first stage is never read elsewhere
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access
    logic [1:0]  sel;
    logic        wr_en;
    logic [13:0] gain_setting_r;
    logic [13:0] offset_correction_value_r;
    logic [13:0] converter_control_r;
    logic        we_d_r;

    assign sel = {register_select_high, register_select_low};

    // Write taken on the first cycle the strobe is seen low with chip select
    // A strobe held low writes once; the host raises it between writes
    assign wr_en = !chip_select_n && !write_n && !we_d_r;

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            we_d_r <= 1'b0;
        end else begin
            we_d_r <= !chip_select_n && !write_n;
        end
    end

    // Decode of one register write, shared by the three register processes
    function automatic logic write_hit(input logic       en,
                                       input logic [1:0] s,
                                       input logic [1:0] code);
        return en && (s == code);
    endfunction : write_hit

    // Gain register; full word stored, unused bits read back as written
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            gain_setting_r <= adc_ctrl_pkg::GAIN_RST;
        end else if (write_hit(wr_en, sel, adc_ctrl_pkg::SEL_GAIN)) begin
            gain_setting_r <= data_in;
        end
    end

    // Offset register; only its low eight bits reach the subtractor
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            offset_correction_value_r <= adc_ctrl_pkg::OFFSET_RST;
        end else if (write_hit(wr_en, sel, adc_ctrl_pkg::SEL_OFFSET)) begin
            offset_correction_value_r <= data_in;
        end
    end

    // Control register; a write to the result select is simply ignored
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            converter_control_r <= adc_ctrl_pkg::CONTROL_RST;
        end else if (write_hit(wr_en, sel, adc_ctrl_pkg::SEL_CONTROL)) begin
            converter_control_r <= data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control decode
    logic [2:0] tm;

    assign gain_step_code = gain_setting_r[adc_ctrl_pkg::GAIN_W-1:0];
    assign bandgap_voltage_node_ext = converter_control_r[adc_ctrl_pkg::CTL_REF_BIT];
    assign power_down = converter_control_r[adc_ctrl_pkg::CTL_PWD_BIT];
    assign tm = converter_control_r[adc_ctrl_pkg::CTL_TM_LSB +: 3];

    // Test input routing
    // Codes 000 and 100 take the default and keep the signal path
    always_comb begin
        input_route = '{adc_ctrl_pkg::SRC_SIGNAL, adc_ctrl_pkg::SRC_SIGNAL};
        case (tm)
            adc_ctrl_pkg::TM_BOTH_LO:
                input_route = '{adc_ctrl_pkg::SRC_REF_LO, adc_ctrl_pkg::SRC_REF_LO};
            adc_ctrl_pkg::TM_MID_LO:
                input_route = '{adc_ctrl_pkg::SRC_REF_MID, adc_ctrl_pkg::SRC_REF_LO};
            adc_ctrl_pkg::TM_HI_LO:
                input_route = '{adc_ctrl_pkg::SRC_REF_HI, adc_ctrl_pkg::SRC_REF_LO};
            adc_ctrl_pkg::TM_BOTH_HI:
                input_route = '{adc_ctrl_pkg::SRC_REF_HI, adc_ctrl_pkg::SRC_REF_HI};
            adc_ctrl_pkg::TM_LO_MID:
                input_route = '{adc_ctrl_pkg::SRC_REF_LO, adc_ctrl_pkg::SRC_REF_MID};
            adc_ctrl_pkg::TM_LO_HI:
                input_route = '{adc_ctrl_pkg::SRC_REF_LO, adc_ctrl_pkg::SRC_REF_HI};
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset correction
    logic signed [15:0] corr;
    logic signed [15:0] off_ext;
    logic [13:0]        corr_sat;
    logic [13:0]        fmt_code;

    // Offset is an 8-bit two's complement value, sign-extended
    // Upper bits of the offset word are kept for read-back but never used
    assign off_ext = 16'(signed'(offset_correction_value_r[adc_ctrl_pkg::OFFSET_W-1:0]));

    always_comb begin
        if (!converter_control_r[adc_ctrl_pkg::CTL_OFF_BIT]) begin
            corr = signed'({2'h0, sample_code}) - off_ext;
        end else begin
            corr = signed'({2'h0, sample_code});
        end
        // Clip rather than wrap so a large offset cannot flip full scale
        if (corr < 16'sh0000) begin
            corr_sat = 14'h0000;
        end else if (corr > 16'sh3fff) begin
            corr_sat = 14'h3fff;
        end else begin
            corr_sat = corr[13:0];
        end
    end

    // Two's complement output flips the top bit of the straight binary code
    assign fmt_code = converter_control_r[adc_ctrl_pkg::CTL_FMT_BIT] ?
                      {~corr_sat[13], corr_sat[12:0]} : corr_sat;

    ////////////////////////////////////////////////////////////////////////////
    // Output pipeline; flag and code share every stage
    adc_ctrl_pkg::sample_s pipe_r   [PIPE_DEPTH];
    adc_ctrl_pkg::sample_s stage_in [PIPE_DEPTH];
    logic                  range_flag_r;

    // First stage takes the corrected code together with the core's range flag
    assign stage_in[0] = '{fmt_code, sample_over};

    // One register per stage; a stage moves only when the core delivers a sample
    for (genvar g = 0; g < PIPE_DEPTH; g++) begin : g_stage
        if (g > 0) begin : g_link
            assign stage_in[g] = pipe_r[g-1];
        end
        always_ff @(posedge sys_clk or negedge rst_n_r) begin
            if (!rst_n_r) begin
                pipe_r[g] <= '0;
            end else if (sample_valid) begin
                pipe_r[g] <= stage_in[g];
            end
        end
    end

    // Retimed like data_out, so the flag changes on the edge the result does
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            range_flag_r <= 1'b0;
        end else begin
            range_flag_r <= pipe_r[PIPE_DEPTH-1].out_of_range;
        end
    end

    assign out_of_range_flag = range_flag_r;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and bus drive
    // The selected word reaches the bus one clock after the select settles
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            data_out <= 14'h0000;
        end else begin
            case (sel)
                adc_ctrl_pkg::SEL_RESULT:  data_out <= pipe_r[PIPE_DEPTH-1].code;
                adc_ctrl_pkg::SEL_GAIN:    data_out <= gain_setting_r;
                adc_ctrl_pkg::SEL_OFFSET:  data_out <= offset_correction_value_r;
                default:                   data_out <= converter_control_r;
            endcase
        end
    end

    // Drive only while enabled by the host
    // The three-state buffers sit at the pads; this is only their enable
    assign data_oe = {14{!output_enable_n && !chip_select_n && rst_n_r}};

endmodule : adc_host_config_and_correction

/* sim/adc_host_properties.sv */
// Port checks of the converter control block
`timescale 1ns/1ps
module adc_host_properties (
    input wire logic        sys_clk, // Clock
    input wire logic        nrst, // Reset
    input wire logic        chip_select_n, // Select
    input wire logic        write_n, // Strobe
    input wire logic        output_enable_n, // Enable
    input wire logic        register_select_high, // Select 1
    input wire logic        register_select_low, // Select 0
    input wire logic [13:0] data_in, // Write data
    input wire logic [13:0] data_out, // Read data
    input wire logic [13:0] data_oe, // Drive
    input wire logic        sample_valid, // Push
    input wire logic        out_of_range_flag, // Range
    input wire logic [2:0]  gain_step_code, // Gain
    input wire logic        bandgap_voltage_node_ext, // Ref off
    input wire adc_ctrl_pkg::input_route_s input_route // Route
);
    // Strobe history, so a strobe held low counts as one write
    logic       wn_r;
    logic [1:0] sel;
    logic       wr;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wn_r <= 1'b1;
        end else begin
            wn_r <= write_n;
        end
    end
    assign sel = {register_select_high, register_select_low};
    assign wr = !chip_select_n && !write_n && wn_r;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_oe_off; output_enable_n || chip_select_n |-> data_oe == 14'h0000; endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven");
    property p_oe_on; !output_enable_n && !chip_select_n && $past(nrst) && $past(nrst, 2)
        |-> data_oe == 14'h3fff; endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus not driven");
    property p_gain_wr; wr && sel == 2'h1 |=> gain_step_code == $past(data_in[2:0]); endproperty
    a_gain_wr: assert property (p_gain_wr) else $error("gain not taken");
    property p_gain_hold; !$stable(gain_step_code) |-> $past(wr && sel == 2'h1); endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain moved");
    property p_ref_wr; wr && sel == 2'h3 |=> bandgap_voltage_node_ext == $past(data_in[12]);
    endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("ref select");
    property p_route; wr && sel == 2'h3 && data_in[9:8] == 2'h0 |=> input_route == 4'h0;
    endproperty
    a_route: assert property (p_route) else $error("route not normal");
    property p_ovr; $changed(out_of_range_flag) |-> $past(sample_valid, 2); endproperty
    a_ovr: assert property (p_ovr) else $error("flag off step");
    property p_ctl_rd; $past(sel) == 2'h3 && !$past(wr) |-> data_out[12] == bandgap_voltage_node_ext;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
endmodule : adc_host_properties
bind adc_host_config_and_correction adc_host_properties adc_host_properties_inst (.sys_clk,
    .nrst, .chip_select_n, .write_n, .output_enable_n, .register_select_high,
    .register_select_low, .data_in, .data_out, .data_oe, .sample_valid, .out_of_range_flag,
    .gain_step_code, .bandgap_voltage_node_ext, .input_route);

/* sim/host_model.sv */
// Host processor model on the parallel register port
`timescale 1ns/1ps
module host_model (
    input  wire logic        sys_clk, // Clock
    output logic             chip_select_n = 1'b1, // Select
    output logic             write_n = 1'b1, // Strobe
    output logic             output_enable_n = 1'b1, // Enable
    output logic [1:0]       sel = 2'h0, // Register
    output logic [13:0]      data_in = 14'h2aaa, // Write data
    input  wire logic [13:0] data_out, // Read data
    input  wire logic [13:0] data_oe // Drive
);
    // One write edge, then release with inverted data so stale values never match
    task automatic wr(input logic [1:0] a, input logic [13:0] d);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        write_n <= 1'b0;
        sel <= a;
        data_in <= d;
        @(posedge sys_clk);
        chip_select_n <= 1'b1;
        write_n <= 1'b1;
        data_in <= ~d;
    endtask : wr
    // Read held two edges, since the data is registered behind the select
    task automatic rd(input logic [1:0] a, output logic [13:0] q, output logic [13:0] oe);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        output_enable_n <= 1'b0;
        sel <= a;
        repeat (2) @(posedge sys_clk);
        q = data_out;
        oe = data_oe;
        chip_select_n <= 1'b1;
        output_enable_n <= 1'b1;
    endtask : rd
endmodule : host_model

/* sim/adc_host_config_and_correction_tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module adc_host_config_and_correction_tb;
    localparam int DEPTH = 2;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        sample_valid = 1'b0;
    logic        sample_over = 1'b0;
    logic [13:0] sample_code = 14'h0000;
    logic        cs_n, wr_n, oe_n, ovr, bg, pd;
    logic [1:0]  sel;
    logic [2:0]  gain;
    logic [13:0] din, dout, doe, q, oe;
    adc_ctrl_pkg::input_route_s route;
    int          errors = 0;
    int          comparisons = 0;
    // Rows: expected input routing above the control word written
    logic [17:0] rows [9] = '{18'h00000, 18'h14100, 18'h24200, 18'h35300,
                              18'h00400, 18'h3c500, 18'h18600, 18'h1c780,
                              18'h02000};
    always #12.5 sys_clk = ~sys_clk;
    adc_host_config_and_correction #(.PIPE_DEPTH(DEPTH)) adc_host_config_and_correction_inst (
        .sys_clk, .nrst, .chip_select_n(cs_n), .write_n(wr_n), .output_enable_n(oe_n),
        .register_select_high(sel[1]), .register_select_low(sel[0]), .data_in(din),
        .data_out(dout), .data_oe(doe), .sample_valid, .sample_code, .sample_over,
        .out_of_range_flag(ovr), .gain_step_code(gain), .bandgap_voltage_node_ext(bg),
        .power_down(pd), .input_route(route));
    host_model host_model_inst (.sys_clk, .chip_select_n(cs_n), .write_n(wr_n),
        .output_enable_n(oe_n), .sel, .data_in(din), .data_out(dout), .data_oe(doe));
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [1:0] a, input logic [13:0] exp);
        host_model_inst.rd(a, q, oe);
        chk(q, exp);
    endtask : rchk
    task automatic end_of_test();
        $display("%0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Reset, then wait out the internal release before the first access
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : do_reset
    // Push one sample then fillers, so it just reaches the last stage
    task automatic feed(input logic [13:0] c, input logic o);
        for (int i = 0; i < DEPTH; i++) begin
            @(posedge sys_clk);
            sample_valid <= 1'b1;
            sample_code <= c;
            sample_over <= (i == 0) ? o : 1'b0;
        end
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        sample_code <= ~c;
    endtask : feed
    initial begin
        do_reset();
        foreach (rows[i]) begin
            host_model_inst.wr(2'h3, rows[i][13:0]);
            rchk(2'h3, rows[i][13:0]);
            chk(oe, 14'h3fff);
            chk({10'h000, route}, {10'h000, rows[i][17:14]});
            chk({13'h0000, bg}, {13'h0000, rows[i][12]});
            chk({13'h0000, pd}, {13'h0000, rows[i][13]});
        end
        $display("control rows done");
        host_model_inst.wr(2'h1, 14'h0007);
        rchk(2'h1, 14'h0007);
        chk({11'h000, gain}, 14'h0007);
        @(negedge sys_clk);
        chk(doe, 14'h0000);
        $display("gain done");
        // Calibrate in twos complement: a zero input reads back as the raw offset
        host_model_inst.wr(2'h3, 14'h0800);
        feed(14'h2005, 1'b0);
        rchk(2'h0, 14'h0005);
        host_model_inst.wr(2'h2, q);
        feed(14'h2005, 1'b0);
        rchk(2'h0, 14'h0000);
        feed(14'h0002, 1'b1);
        rchk(2'h0, 14'h2000);
        chk({13'h0000, ovr}, 14'h0001);
        host_model_inst.wr(2'h3, 14'h0880);
        feed(14'h2005, 1'b0);
        rchk(2'h0, 14'h0005);
        chk({13'h0000, ovr}, 14'h0000);
        // Straight binary with an offset of -1 must clip at full scale
        host_model_inst.wr(2'h3, 14'h0000);
        host_model_inst.wr(2'h2, 14'h00ff);
        feed(14'h3fff, 1'b1);
        rchk(2'h0, 14'h3fff);
        chk({13'h0000, ovr}, 14'h0001);
        $display("offset done");
        do_reset();
        for (int a = 1; a < 4; a++) begin
            rchk(a[1:0], 14'h0000);
        end
        $display("reset values done");
        end_of_test();
    end
    // Watchdog: the sequence needs just over a hundred cycles
    initial begin
        #(2000 * 25);
        errors++;
        end_of_test();
    end
endmodule : adc_host_config_and_correction_tb
